// *** hdl/dncs_pin_ctr.sv ***
// dncs_pin_ctr: select pin synchroniser, edge detect and wrapping counter
// assumes raw pins are asynchronous to clk_i
`timescale 1ns/1ps
module dncs_pin_ctr (
  // clock and reset
  input  wire logic   clk_i,
  input  wire logic   rst_i,
  // counter side
  dncs_ctr_if.counter ctr
);
  logic [3:0] meta_r;
  logic [3:0] sync_r;
  logic [3:0] prev_r;
  logic [3:0] count_r;
  logic       edge_mode;
  logic [1:0] src;
  logic       rise;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_r <= 4'h0;
      sync_r <= 4'h0;
      prev_r <= 4'h0;
    end else begin
      meta_r <= ctr.pins_raw;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign edge_mode = (ctr.mode[3:2] == dncs_pkg::MODE_EDGE_A0[3:2]);
  assign src       = ctr.mode[1:0];
  assign rise      = edge_mode & sync_r[src] & ~prev_r[src];

  // wraps to zero on the edge after the count equals the field
  always_ff @(posedge clk_i) begin
    if (rst_i || !edge_mode) begin
      count_r <= 4'h0;
    end else if (rise) begin
      count_r <= (count_r >= ctr.wrap) ? 4'h0 : count_r + 4'h1;
    end
  end

  assign ctr.pins_sync = sync_r;
  assign ctr.count     = count_r;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_rise_below;
    rise && (count_r < ctr.wrap);
  endsequence

  AST_CNT_STEP: assert property (
      s_rise_below |=> count_r == $past(count_r) + 4'h1)
    else $error("edge did not advance the channel counter");
  AST_CNT_WRAP: assert property (
      rise && count_r >= ctr.wrap |=> count_r == 4'h0)
    else $error("channel counter did not wrap");
  AST_CNT_HOLD: assert property (
      !rise ##1 edge_mode |-> $stable(count_r))
    else $error("channel counter moved without an edge");
endmodule : dncs_pin_ctr

// *** hdl/dncs_top.sv ***
// dncs_top: nco channel and i/q input selection of one downconverter path
// assumes a classic wishbone master on clk_i and asynchronous select pins
`timescale 1ns/1ps
module dncs_top #(
  parameter int unsigned DATA_W = 16
) (
  // clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // wishbone slave
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [11:0]           wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output      logic [31:0]           wb_dat_o,
  output      logic                  wb_ack_o,
  // select pins from the external controller
  input  wire logic                  sel_pin_a0_i,
  input  wire logic                  sel_pin_a1_i,
  input  wire logic                  sel_pin_b0_i,
  input  wire logic                  sel_pin_b1_i,
  // converter samples
  input  wire logic [DATA_W-1:0]     adc_a_i,
  input  wire logic [DATA_W-1:0]     adc_b_i,
  input  wire logic                  adc_valid_i,
  // mixer inputs
  output      logic [DATA_W-1:0]     i_data_o,
  output      logic [DATA_W-1:0]     q_data_o,
  output      logic                  iq_valid_o,
  // nco selection
  output      logic [3:0]            nco_chan_o,
  input  wire logic                  chip_xfer_i,
  output      logic [3:0]            phase_upd_idx_o
);

  dncs_ctr_if ctr ();

  // register state
  logic                  route_i_r;
  logic                  route_q_r;
  dncs_pkg::dncs_chan_type chan_r;
  logic [3:0]            mode_r;
  logic [3:0]            upd_idx_r;
  logic                  upd_xfer_r;

  // bus state
  logic                  ack_r;
  logic [31:0]           rd_data_r;
  logic [31:0]           rd_nxt;
  logic                  req;
  logic                  wr_fire;
  logic                  wr_lane0;
  logic                  hit_routing;
  logic                  hit_ctrl;
  logic                  hit_upd;
  logic                  hit_status;

  // datapath state
  logic [DATA_W-1:0]     i_data_r;
  logic [DATA_W-1:0]     q_data_r;
  logic                  iq_valid_r;
  dncs_pkg::dncs_chan_type act_chan_r;
  dncs_pkg::dncs_chan_type act_nxt;
  logic [3:0]            phase_upd_r;

  // pin counter
  assign ctr.pins_raw = {sel_pin_b1_i, sel_pin_b0_i,
                         sel_pin_a1_i, sel_pin_a0_i};
  assign ctr.mode     = mode_r;
  assign ctr.wrap     = chan_r;

  dncs_pin_ctr u_pin_ctr (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ctr   (ctr.counter)
  );

  // address decode on word addresses
  function automatic logic hit(input logic [11:0] adr,
                               input logic [11:0] ofs);
    hit = (adr[11:2] == ofs[11:2]);
  endfunction : hit

  // channel index for a given mode
  function automatic dncs_pkg::dncs_chan_type pick_chan(
    input logic [3:0]              mode,
    input logic [3:0]              p,
    input dncs_pkg::dncs_chan_type chan,
    input logic [3:0]              count
  );
    dncs_pkg::dncs_chan_type r;
    r = chan;
    unique case (mode)
      dncs_pkg::MODE_REG: begin
        r = chan;
      end
      dncs_pkg::MODE_B0A0: begin
        r = {2'b00, p[dncs_pkg::PIN_B0], p[dncs_pkg::PIN_A0]};
      end
      dncs_pkg::MODE_B1A1: begin
        r = {2'b00, p[dncs_pkg::PIN_B1], p[dncs_pkg::PIN_A1]};
      end
      dncs_pkg::MODE_A1A0: begin
        r = {2'b00, p[dncs_pkg::PIN_A1], p[dncs_pkg::PIN_A0]};
      end
      dncs_pkg::MODE_B1B0: begin
        r = {2'b00, p[dncs_pkg::PIN_B1], p[dncs_pkg::PIN_B0]};
      end
      dncs_pkg::MODE_B1A1B0A0: begin
        r = {p[dncs_pkg::PIN_B1], p[dncs_pkg::PIN_A1],
             p[dncs_pkg::PIN_B0], p[dncs_pkg::PIN_A0]};
      end
      dncs_pkg::MODE_B1B0A1A0: begin
        r = {p[dncs_pkg::PIN_B1], p[dncs_pkg::PIN_B0],
             p[dncs_pkg::PIN_A1], p[dncs_pkg::PIN_A0]};
      end
      dncs_pkg::MODE_EDGE_A0,
      dncs_pkg::MODE_EDGE_A1,
      dncs_pkg::MODE_EDGE_B0,
      dncs_pkg::MODE_EDGE_B1: begin
        r = count;
      end
      default: begin
        r = chan;
      end
    endcase
    return r;
  endfunction : pick_chan

  assign req         = wb_cyc_i & wb_stb_i;
  assign hit_routing = hit(wb_adr_i, dncs_pkg::OFS_ROUTING);
  assign hit_ctrl    = hit(wb_adr_i, dncs_pkg::OFS_NCO_CTRL);
  assign hit_upd     = hit(wb_adr_i, dncs_pkg::OFS_PHASE_UPD);
  assign hit_status  = hit(wb_adr_i, dncs_pkg::OFS_STATUS);

  // write lands on the edge at which the master sees ack
  assign wr_fire  = req & wb_we_i & ack_r;
  assign wr_lane0 = wr_fire & wb_sel_i[0];

  // one wait state, ack dropped right after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req & ~ack_r;
    end
  end

  // read mux, unmapped words read as zero
  always_comb begin
    rd_nxt = 32'h0000_0000;
    if (hit_routing) begin
      rd_nxt[dncs_pkg::ROUTE_I_BIT] = route_i_r;
      rd_nxt[dncs_pkg::ROUTE_Q_BIT] = route_q_r;
    end else if (hit_ctrl) begin
      rd_nxt[dncs_pkg::CHAN_LSB +: 4] = chan_r;
      rd_nxt[dncs_pkg::MODE_LSB +: 4] = mode_r;
    end else if (hit_upd) begin
      rd_nxt[dncs_pkg::UPD_IDX_LSB +: 4] = upd_idx_r;
      rd_nxt[dncs_pkg::UPD_XFER_BIT]     = upd_xfer_r;
    end else if (hit_status) begin
      rd_nxt[dncs_pkg::STAT_ACT_LSB +: 4] = act_chan_r;
      rd_nxt[dncs_pkg::STAT_CNT_LSB +: 4] = ctr.count;
      rd_nxt[dncs_pkg::STAT_PIN_LSB +: 4] = ctr.pins_sync;
      rd_nxt[dncs_pkg::STAT_UPD_LSB +: 4] = phase_upd_r;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_data_r <= 32'h0000_0000;
    end else if (req & ~ack_r & ~wb_we_i) begin
      rd_data_r <= rd_nxt;
    end else if (ack_r) begin
      rd_data_r <= 32'h0000_0000;
    end
  end

  // input routing register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      route_i_r <= dncs_pkg::ROUTE_I_RST;
      route_q_r <= dncs_pkg::ROUTE_Q_RST;
    end else if (wr_lane0 && hit_routing) begin
      route_i_r <= wb_dat_i[dncs_pkg::ROUTE_I_BIT];
      route_q_r <= wb_dat_i[dncs_pkg::ROUTE_Q_BIT];
    end
  end

  // nco control register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chan_r <= dncs_pkg::CHAN_RST;
      mode_r <= dncs_pkg::MODE_RST;
    end else if (wr_lane0 && hit_ctrl) begin
      chan_r <= wb_dat_i[dncs_pkg::CHAN_LSB +: 4];
      mode_r <= wb_dat_i[dncs_pkg::MODE_LSB +: 4];
    end
  end

  // phase update register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      upd_idx_r  <= dncs_pkg::UPD_IDX_RST;
      upd_xfer_r <= dncs_pkg::UPD_XFER_RST;
    end else if (wr_lane0 && hit_upd) begin
      upd_idx_r  <= wb_dat_i[dncs_pkg::UPD_IDX_LSB +: 4];
      upd_xfer_r <= wb_dat_i[dncs_pkg::UPD_XFER_BIT];
    end
  end

  // i/q source selection
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      i_data_r   <= '0;
      q_data_r   <= '0;
      iq_valid_r <= 1'b0;
    end else begin
      iq_valid_r <= adc_valid_i;
      if (adc_valid_i) begin
        i_data_r <= route_i_r ? adc_b_i : adc_a_i;
        q_data_r <= route_q_r ? adc_b_i : adc_a_i;
      end
    end
  end

  // active nco channel
  assign act_nxt = pick_chan(mode_r, ctr.pins_sync, chan_r, ctr.count);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      act_chan_r <= dncs_pkg::CHAN_RST;
    end else begin
      act_chan_r <= act_nxt;
    end
  end

  // continuous follow, or capture on a chip transfer strobe
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_upd_r <= dncs_pkg::UPD_IDX_RST;
    end else if (!upd_xfer_r || chip_xfer_i) begin
      phase_upd_r <= upd_idx_r;
    end
  end

  assign wb_ack_o        = ack_r;
  assign wb_dat_o        = rd_data_r;
  assign i_data_o        = i_data_r;
  assign q_data_o        = q_data_r;
  assign iq_valid_o      = iq_valid_r;
  assign nco_chan_o      = act_chan_r;
  assign phase_upd_idx_o = phase_upd_r;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_ctrl_write;
    wr_lane0 && hit_ctrl;
  endsequence

  sequence s_mode_held(logic [3:0] m);
    (mode_r == m) ##1 (mode_r == m);
  endsequence

  AST_ROUTE_I: assert property (adc_valid_i |=>
      i_data_o == ($past(route_i_r) ? $past(adc_b_i) : $past(adc_a_i)))
    else $error("i input taken from the wrong converter channel");

  AST_ROUTE_Q: assert property (adc_valid_i |=>
      q_data_o == ($past(route_q_r) ? $past(adc_b_i) : $past(adc_a_i)))
    else $error("q input taken from the wrong converter channel");

  AST_MODE_REG: assert property (mode_r == dncs_pkg::MODE_REG |=>
      nco_chan_o == $past(chan_r))
    else $error("register mode channel not followed");

  AST_MODE_B0A0: assert property (mode_r == dncs_pkg::MODE_B0A0 |=>
      nco_chan_o == {2'b00, $past(ctr.pins_sync[dncs_pkg::PIN_B0]),
                     $past(ctr.pins_sync[dncs_pkg::PIN_A0])})
    else $error("mode 1 channel index wrong");

  AST_MODE_B1A1: assert property (mode_r == dncs_pkg::MODE_B1A1 |=>
      nco_chan_o == {2'b00, $past(ctr.pins_sync[dncs_pkg::PIN_B1]),
                     $past(ctr.pins_sync[dncs_pkg::PIN_A1])})
    else $error("mode 2 channel index wrong");

  AST_MODE_PAIRS: assert property (
      s_mode_held(dncs_pkg::MODE_A1A0) or s_mode_held(dncs_pkg::MODE_B1B0)
      |-> nco_chan_o == {2'b00, (mode_r == dncs_pkg::MODE_A1A0) ?
          $past(ctr.pins_sync[1:0]) :
          $past(ctr.pins_sync[3:2])})
    else $error("mode 3 or 4 channel index wrong");

  AST_MODE_MIX5: assert property (mode_r == dncs_pkg::MODE_B1A1B0A0 |=>
      nco_chan_o == {$past(ctr.pins_sync[3]), $past(ctr.pins_sync[1]),
                     $past(ctr.pins_sync[2]), $past(ctr.pins_sync[0])})
    else $error("mode 5 channel index wrong");

  AST_MODE_MIX6: assert property (mode_r == dncs_pkg::MODE_B1B0A1A0 |=>
      nco_chan_o == $past(ctr.pins_sync))
    else $error("mode 6 channel index wrong");

  AST_EDGE_FOLLOW: assert property (mode_r[3:2] == 2'b10 |=>
      nco_chan_o == $past(ctr.count))
    else $error("edge mode channel not taken from counter");

  AST_CHAN_WRITE: assert property (
      s_ctrl_write and (wb_dat_i[7:4] == dncs_pkg::MODE_REG) |=>
      ##1 nco_chan_o == $past(wb_dat_i[3:0], 2))
    else $error("written channel field not selected");

  AST_UPD_CONT: assert property (!upd_xfer_r |=>
      phase_upd_idx_o == $past(upd_idx_r))
    else $error("continuous phase update index not followed");

  AST_UPD_XFER: assert property (upd_xfer_r && !chip_xfer_i |=>
      $stable(phase_upd_idx_o))
    else $error("phase update index moved without a transfer");

endmodule : dncs_top

// *** shared/dncs_ctr_if.sv ***
// dncs_ctr_if: link between the select top and its pin counter
// assumes both ends share one clock
`timescale 1ns/1ps
interface dncs_ctr_if;
  logic [3:0] pins_raw;
  logic [3:0] mode;
  logic [3:0] wrap;
  logic [3:0] pins_sync;
  logic [3:0] count;

  modport owner   (output pins_raw, mode, wrap,
                   input  pins_sync, count);
  modport counter (input  pins_raw, mode, wrap,
                   output pins_sync, count);
endinterface : dncs_ctr_if

// *** shared/dncs_pkg.sv ***
// dncs_pkg: constants for the nco channel select of one downconverter path
// assumes a 32-bit classic wishbone slave and a four-bit nco channel index
// Behaviour
// - mode 0 takes channel from register field
// - mode 1 index is 00, b0, a0
// - mode 2 index is 00, b1, a1
// - mode 3 is 00,a1,a0; mode 4 00,b1,b0
// - mode 5 index is b1, a1, b0, a0
// - mode 6 index is b1, b0, a1, a0
// - modes 8 to 11 count pin rising edges
// - edge counter wraps after reaching channel field
// - channel field picks channel 0 to 15, reset 0
// - phase update index picks channel to update
package dncs_pkg;
  typedef logic [3:0] dncs_chan_type;

  localparam int unsigned WB_ADR_W      = 12;
  localparam logic [11:0] OFS_ROUTING   = 12'h370;
  localparam logic [11:0] OFS_NCO_CTRL  = 12'h374;
  localparam logic [11:0] OFS_PHASE_UPD = 12'h378;
  localparam logic [11:0] OFS_STATUS    = 12'h37c;

  localparam int unsigned ROUTE_I_BIT   = 0;
  localparam int unsigned ROUTE_Q_BIT   = 2;
  localparam logic        ROUTE_I_RST   = 1'b0;
  localparam logic        ROUTE_Q_RST   = 1'b1;

  localparam int unsigned CHAN_LSB      = 0;
  localparam int unsigned MODE_LSB      = 4;
  localparam logic [3:0]  CHAN_RST      = 4'h0;
  localparam logic [3:0]  MODE_RST      = 4'h0;

  localparam int unsigned UPD_IDX_LSB   = 0;
  localparam int unsigned UPD_XFER_BIT  = 4;
  localparam logic [3:0]  UPD_IDX_RST   = 4'h0;
  localparam logic        UPD_XFER_RST  = 1'b0;

  localparam int unsigned STAT_ACT_LSB  = 0;
  localparam int unsigned STAT_CNT_LSB  = 4;
  localparam int unsigned STAT_PIN_LSB  = 8;
  localparam int unsigned STAT_UPD_LSB  = 12;

  localparam int unsigned PIN_A0        = 0;
  localparam int unsigned PIN_A1        = 1;
  localparam int unsigned PIN_B0        = 2;
  localparam int unsigned PIN_B1        = 3;

  localparam logic [3:0]  MODE_REG      = 4'h0;
  localparam logic [3:0]  MODE_B0A0     = 4'h1;
  localparam logic [3:0]  MODE_B1A1     = 4'h2;
  localparam logic [3:0]  MODE_A1A0     = 4'h3;
  localparam logic [3:0]  MODE_B1B0     = 4'h4;
  localparam logic [3:0]  MODE_B1A1B0A0 = 4'h5;
  localparam logic [3:0]  MODE_B1B0A1A0 = 4'h6;
  localparam logic [3:0]  MODE_EDGE_A0  = 4'h8;
  localparam logic [3:0]  MODE_EDGE_A1  = 4'h9;
  localparam logic [3:0]  MODE_EDGE_B0  = 4'ha;
  localparam logic [3:0]  MODE_EDGE_B1  = 4'hb;
endpackage : dncs_pkg

// *** tb/dncs_sel_ctl.sv ***
// dncs_sel_ctl: behavioural controller that drives the four select pins
// assumes the select block samples the pins on clk_i
`timescale 1ns/1ps
module dncs_sel_ctl (
  // clock
  input  wire logic       clk_i,
  // select pins {b1,b0,a1,a0}
  output      logic [3:0] pins_o
);
  initial pins_o = 4'h0;

  // hold levels for a pin-indexed mode
  task automatic set_lvl(input logic [3:0] p);
    @(posedge clk_i);
    pins_o <= p;
  endtask : set_lvl

  // three cycles high, three low: beyond the synchroniser minimum
  task automatic pulse(input int k);
    @(posedge clk_i);
    pins_o[k] <= 1'b1;
    repeat (3) @(posedge clk_i);
    pins_o[k] <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask : pulse
endmodule : dncs_sel_ctl

// *** tb/dncs_top_bench.sv ***
// dncs_top_bench: self-checking bench for the nco channel select block
// assumes a one-cycle wishbone ack and the pin controller model
`timescale 1ns/1ps
module dncs_top_bench;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc   = 1'b0;
  logic        stb   = 1'b0;
  logic        we    = 1'b0;
  logic        xfer  = 1'b0;
  logic        adc_v = 1'b0;
  logic [11:0] adr   = 12'h000;
  logic [3:0]  sel   = 4'h0;
  logic [31:0] wdat  = 32'h0;
  logic [15:0] adc_a = 16'h0;
  logic [15:0] adc_b = 16'h0;
  logic [31:0] rdat, e;
  logic [15:0] i_d, q_d;
  logic [3:0]  pins, chan, upd;
  logic        ack, iq_v;
  int          mismatches = 0;
  int          compares   = 0;
  logic [31:0] rq[$];
  logic [31:0] iq[$];

  dncs_sel_ctl ctl (.clk_i(clk_i), .pins_o(pins));

  dncs_top i_dut (
    .clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .sel_pin_a0_i(pins[0]), .sel_pin_a1_i(pins[1]),
    .sel_pin_b0_i(pins[2]), .sel_pin_b1_i(pins[3]),
    .adc_a_i(adc_a), .adc_b_i(adc_b), .adc_valid_i(adc_v),
    .i_data_o(i_d), .q_data_o(q_d), .iq_valid_o(iq_v),
    .nco_chan_o(chan), .chip_xfer_i(xfer), .phase_upd_idx_o(upd)
  );

  always #5 clk_i = ~clk_i;

  task automatic report_and_stop;
    if (mismatches == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk_bus(input string n, input logic [31:0] x, g);
    compares++;
    if (g !== x) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, x, g);
    end
  endtask : chk_bus

  task automatic chk_nib(input string n, input logic [3:0] x, g);
    compares++;
    if (g !== x) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, x, g);
    end
  endtask : chk_nib

  task automatic wb_xfer(input logic w, input logic [11:0] a,
                         input logic [31:0] d, input logic [3:0] s);
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= s;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb_xfer

  task automatic wb_wr(input logic [11:0] a, input logic [31:0] d);
    wb_xfer(1'b1, a, d, 4'hf);
  endtask : wb_wr

  task automatic wb_rd(input logic [11:0] a, input logic [31:0] x);
    rq.push_back(x);
    wb_xfer(1'b0, a, 32'h0, 4'hf);
  endtask : wb_rd

  // expected index from mode, pins {b1,b0,a1,a0} and channel field
  function automatic logic [3:0] exp_idx(input logic [3:0] m, p, ch);
    case (m)
      4'h1:    return {2'b00, p[2], p[0]};
      4'h2:    return {2'b00, p[3], p[1]};
      4'h3:    return {2'b00, p[1], p[0]};
      4'h4:    return {2'b00, p[3], p[2]};
      4'h5:    return {p[3], p[1], p[2], p[0]};
      4'h6:    return p;
      default: return ch;
    endcase
  endfunction : exp_idx

  // oldest note is compared whenever a result shows
  always @(posedge clk_i) begin
    if (ack === 1'b1 && we === 1'b0) begin
      e = rq.size() > 0 ? rq.pop_front() : 32'hxxxx_xxxx;
      chk_bus("read", e, rdat);
    end
    if (iq_v === 1'b1) begin
      e = iq.size() > 0 ? iq.pop_front() : 32'hxxxx_xxxx;
      chk_bus("iq", e, {i_d, q_d});
    end
  end

  initial begin : watchdog
    repeat (20000) @(posedge clk_i);
    mismatches++;
    report_and_stop();
  end

  initial begin : main
    logic [3:0]  p, ch, m, x;
    logic [15:0] ra, rb;
    int          cnt;
    void'($urandom(19));
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    wb_rd(12'h370, 32'h4);
    wb_rd(12'h374, 32'h0);
    wb_rd(12'h378, 32'h0);
    wb_wr(12'h100, 32'hff);
    wb_rd(12'h100, 32'h0);
    for (int r = 0; r < 4; r++) begin
      wb_wr(12'h370, {29'h0, r[1], 1'b0, r[0]});
      repeat (4) begin
        ra = 16'($urandom);
        rb = 16'($urandom);
        @(posedge clk_i);
        adc_a <= ra;
        adc_b <= rb;
        adc_v <= 1'b1;
        iq.push_back({r[0] ? rb : ra, r[1] ? rb : ra});
      end
      @(posedge clk_i);
      adc_v <= 1'b0;
    end
    for (int c = 0; c < 16; c++) begin
      wb_wr(12'h374, {28'h0, 4'(c)});
      repeat (3) @(posedge clk_i);
      chk_nib("chan", 4'(c), chan);
    end
    // byte 0 not enabled: write dropped
    wb_xfer(1'b1, 12'h374, 32'h15, 4'he);
    wb_rd(12'h374, 32'hf);
    // last pass uses unassigned mode 12, which falls back to the field
    for (int k = 0; k < 9; k++) begin
      m  = (k == 8) ? 4'hc : 4'(k);
      ch = 4'($urandom);
      wb_wr(12'h374, {24'h0, m, ch});
      repeat (3) begin
        p = 4'($urandom);
        ctl.set_lvl(p);
        repeat (5) @(posedge clk_i);
        x = exp_idx(m, p, ch);
        chk_nib("chan", x, chan);
      end
    end
    ctl.set_lvl(4'h0);
    for (int k = 0; k < 4; k++) begin
      ch = 4'(1 + k);
      wb_wr(12'h374, {24'h0, 4'(8 + k), ch});
      ctl.pulse((k + 1) % 4);
      chk_nib("chan", 4'h0, chan);
      cnt = 0;
      repeat (6) begin
        ctl.pulse(k);
        cnt = (cnt >= int'(ch)) ? 0 : cnt + 1;
        chk_nib("chan", 4'(cnt), chan);
      end
      wb_rd(12'h37c, {24'h0, 4'(cnt), 4'(cnt)});
      wb_wr(12'h374, 32'h0);
    end
    wb_wr(12'h378, 32'h9);
    repeat (3) @(posedge clk_i);
    chk_nib("upd", 4'h9, upd);
    wb_wr(12'h378, 32'h15);
    repeat (3) @(posedge clk_i);
    chk_nib("upd", 4'h9, upd);
    @(posedge clk_i);
    xfer <= 1'b1;
    @(posedge clk_i);
    xfer <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk_nib("upd", 4'h5, upd);
    report_and_stop();
  end
endmodule : dncs_top_bench
